//--- fcd_defs.svh
// command codes, status bit positions, reset values for the flash command decoder
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH
// command codes taken from the low data byte
`define FCD_CMD_READ_ARRAY   8'hFF
`define FCD_CMD_READ_STATUS  8'h70
`define FCD_CMD_READ_ID      8'h90
`define FCD_CMD_READ_QUERY   8'h98
`define FCD_CMD_CLEAR_STATUS 8'h50
`define FCD_CMD_WORD_PROG    8'h40
`define FCD_CMD_WORD_PROG_ALT 8'h10
`define FCD_CMD_BUF_PROG     8'hE8
`define FCD_CMD_CONFIRM      8'hD0
`define FCD_CMD_FACT_SETUP   8'h80
`define FCD_CMD_SUSPEND      8'hB0
// status register layout
`define FCD_SR_READY         7
`define FCD_SR_ERASE_SUSP    6
`define FCD_SR_ERASE_ERR     5
`define FCD_SR_PROG_ERR      4
`define FCD_SR_VPP_ERR       3
`define FCD_SR_PROG_SUSP     2
`define FCD_SR_LOCK_ERR      1
`define FCD_SR_RESET         8'h80
`define FCD_SR_ERR_MASK      8'h3A
`define FCD_SR_SEQ_ERR       8'h30
// program buffer size in words
`define FCD_BUF_WORDS        32
`endif

//--- fcd_pkg.sv
// types shared by the flash command decoder
package fcd_pkg;
	// read mode presented on the data bus
	typedef enum logic [1:0] {
		FCD_RD_ARRAY,
		FCD_RD_STATUS,
		FCD_RD_IDENT,
		FCD_RD_QUERY
	} fcd_read_mode_type;

	// operation handed to the write state machine
	typedef enum logic [1:0] {
		FCD_OP_NONE,
		FCD_OP_WORD,
		FCD_OP_BUFFER,
		FCD_OP_FACTORY
	} fcd_op_type;

	// one request to the write state machine
	typedef struct packed {
		fcd_op_type  op;
		logic [5:0]  count;
		logic [31:0] addr;
		logic [15:0] data;
	} fcd_wsm_req_type;
endpackage : fcd_pkg

//--- fcd_decoder.sv
// command user interface decoder of a parallel flash device
`timescale 1ns/1ns
`include "fcd_defs.svh"
module fcd_decoder #(
	parameter int ADDR_W = 24
) (
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire logic                 chip_sel_n,
	input  wire logic                 write_en_n,
	input  wire logic                 out_en_n,
	input  wire logic                 address_valid_n,
	input  wire logic [ADDR_W-1:0]    addr,
	input  wire logic [15:0]          dq_in,
	output logic      [15:0]          dq_out,
	output logic                      dq_oe_n,
	output logic      [ADDR_W-1:0]    read_addr,
	input  wire logic [15:0]          array_data,
	input  wire logic [15:0]          ident_data,
	input  wire logic [7:0]           query_data,
	output fcd_pkg::fcd_read_mode_type read_mode,
	output fcd_pkg::fcd_wsm_req_type  wsm_req,
	output logic                      wsm_start,
	output logic                      buf_wr,
	output logic      [15:0]          buf_data,
	output logic      [4:0]           buf_index,
	output logic                      wsm_suspend,
	output logic                      wsm_resume,
	input  wire logic                 wsm_busy,
	input  wire logic                 wsm_suspended,
	input  wire logic [7:0]           wsm_err_set,
	output logic      [7:0]           status
);
	// ==========================================================
	// decoder states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PROG_SETUP,
		ST_BUF_COUNT,
		ST_BUF_LOAD,
		ST_BUF_CONFIRM,
		ST_FACT_SETUP,
		ST_BUSY,
		ST_FACTORY
	} fcd_state_type;

	fcd_state_type                 state_reg;
	fcd_state_type                 state_next;
	fcd_pkg::fcd_read_mode_type    mode_reg;
	fcd_pkg::fcd_read_mode_type    mode_next;
	fcd_pkg::fcd_wsm_req_type      req_reg;
	fcd_pkg::fcd_wsm_req_type      req_next;
	logic [7:0]                    err_reg;
	logic [7:0]                    err_next;
	logic [5:0]                    left_reg;
	logic [5:0]                    left_next;
	logic [4:0]                    idx_reg;
	logic [4:0]                    idx_next;
	logic                          start_next;
	logic                          bufwr_next;
	logic                          susp_next;
	logic                          resume_next;
	logic                          seq_err;
	logic                          clear_err;

	// ==========================================================
	// pin synchronisers: two flops before any logic looks
	logic [2:0]                    wr_sync;
	logic [2:0]                    rd_sync;
	logic [2:0]                    av_sync;
	logic [ADDR_W-1:0]             addr_s1;
	logic [ADDR_W-1:0]             addr_s2;
	logic [15:0]                   data_s1;
	logic [15:0]                   data_s2;
	wire                           wr_level = ~write_en_n & ~chip_sel_n;
	wire                           rd_level = ~out_en_n & ~chip_sel_n;

	// third stage only feeds edge detection
	always_ff @(posedge mclk) begin
		if (reset) begin
			wr_sync <= 3'h0;
			rd_sync <= 3'h0;
			av_sync <= 3'h7;
		end else begin
			wr_sync <= {wr_sync[1:0], wr_level};
			rd_sync <= {rd_sync[1:0], rd_level};
			av_sync <= {av_sync[1:0], address_valid_n};
		end
	end

	// bus values travel alongside the strobes, same latency
	always_ff @(posedge mclk) begin
		addr_s1 <= addr;
		addr_s2 <= addr_s1;
		data_s1 <= dq_in;
		data_s2 <= data_s1;
	end

	// ==========================================================
	// write decode
	// the cycle ends on whichever of write or select rises first
	wire                           wr_done = wr_sync[2] & ~wr_sync[1];
	wire       [7:0]               cmd     = data_s2[7:0];
	wire                           is_prog = (cmd == `FCD_CMD_WORD_PROG) |
	                                         (cmd == `FCD_CMD_WORD_PROG_ALT);
	wire                           is_conf = (cmd == `FCD_CMD_CONFIRM);
	// a read begins on enable/select falling or address valid dropping
	wire                           rd_start = (rd_sync[1] & ~rd_sync[2]) |
	                                          (~av_sync[1] & av_sync[2]);

	// only the command byte matters; the address is never decoded
	function automatic fcd_pkg::fcd_read_mode_type read_cmd_mode(
		input logic [7:0]                 c,
		input fcd_pkg::fcd_read_mode_type cur
	);
		case (c)
			`FCD_CMD_READ_ARRAY:  read_cmd_mode = fcd_pkg::FCD_RD_ARRAY;
			`FCD_CMD_READ_STATUS: read_cmd_mode = fcd_pkg::FCD_RD_STATUS;
			`FCD_CMD_READ_ID:     read_cmd_mode = fcd_pkg::FCD_RD_IDENT;
			`FCD_CMD_READ_QUERY:  read_cmd_mode = fcd_pkg::FCD_RD_QUERY;
			default:              read_cmd_mode = cur;
		endcase
	endfunction : read_cmd_mode

	// ==========================================================
	// command state machine
	always_comb begin
		state_next  = state_reg;
		mode_next   = mode_reg;
		req_next    = req_reg;
		left_next   = left_reg;
		idx_next    = idx_reg;
		start_next  = 1'b0;
		bufwr_next  = 1'b0;
		susp_next   = 1'b0;
		resume_next = 1'b0;
		seq_err     = 1'b0;
		clear_err   = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (wr_done) begin
					mode_next = read_cmd_mode(cmd, mode_reg);
					if (cmd == `FCD_CMD_CLEAR_STATUS) begin
						clear_err = 1'b1;
					end else if (is_prog) begin
						state_next = ST_PROG_SETUP;
						mode_next  = fcd_pkg::FCD_RD_STATUS;
					end else if (cmd == `FCD_CMD_BUF_PROG) begin
						state_next = ST_BUF_COUNT;
						mode_next  = fcd_pkg::FCD_RD_STATUS;
					end else if (cmd == `FCD_CMD_FACT_SETUP) begin
						state_next = ST_FACT_SETUP;
						mode_next  = fcd_pkg::FCD_RD_STATUS;
					end else if (wsm_suspended && is_conf) begin
						resume_next = 1'b1;
						state_next  = ST_BUSY;
						mode_next   = fcd_pkg::FCD_RD_STATUS;
					end
				end
			end
			ST_PROG_SETUP: begin
				// second cycle latches location and data
				if (wr_done) begin
					req_next.op    = fcd_pkg::FCD_OP_WORD;
					req_next.count = 6'h01;
					req_next.addr  = 32'(addr_s2);
					req_next.data  = data_s2;
					start_next     = 1'b1;
					state_next     = ST_BUSY;
				end
			end
			ST_BUF_COUNT: begin
				// first data word gives words minus one; only its low five bits are used, so at most buffer size
				if (wr_done) begin
					left_next      = 6'(data_s2[4:0]) + 6'h01;
					req_next.count = 6'(data_s2[4:0]) + 6'h01;
					req_next.addr  = 32'(addr_s2);
					idx_next       = 5'h00;
					state_next     = ST_BUF_LOAD;
				end
			end
			ST_BUF_LOAD: begin
				// each write streams one word into the program buffer
				if (wr_done) begin
					bufwr_next = 1'b1;
					left_next  = left_reg - 6'h01;
					if (left_reg == 6'h01) begin
						state_next = ST_BUF_CONFIRM;
					end
				end
			end
			ST_BUF_CONFIRM: begin
				if (wr_done) begin
					if (is_conf) begin
						req_next.op = fcd_pkg::FCD_OP_BUFFER;
						start_next  = 1'b1;
						state_next  = ST_BUSY;
					end else begin
						seq_err    = 1'b1;
						state_next = ST_IDLE;
					end
				end
			end
			ST_FACT_SETUP: begin
				if (wr_done) begin
					if (is_conf) begin
						req_next.op    = fcd_pkg::FCD_OP_FACTORY;
						req_next.count = 6'(`FCD_BUF_WORDS);
						req_next.addr  = 32'(addr_s2);
						req_next.data  = data_s2;
						start_next     = 1'b1;
						state_next     = ST_FACTORY;
					end else begin
						seq_err    = 1'b1;
						state_next = ST_IDLE;
					end
				end
			end
			ST_BUSY: begin
				// only status read and suspend are heard while programming
				if (wr_done && cmd == `FCD_CMD_READ_STATUS) begin
					mode_next = fcd_pkg::FCD_RD_STATUS;
				end else if (wr_done && cmd == `FCD_CMD_SUSPEND) begin
					susp_next = 1'b1;
				end
				// the engine answers a start or resume pulse one cycle late; its stale levels are ignored then
				if (!wsm_start && !wsm_resume && (!wsm_busy || wsm_suspended)) begin
					state_next = ST_IDLE;
				end
			end
			ST_FACTORY: begin
				// writes carry factory data only; no code is decoded here
				if (wr_done) begin
					bufwr_next = 1'b1;
				end
				if (!wsm_busy && !start_next && !wsm_start) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// state and request registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			mode_reg  <= fcd_pkg::FCD_RD_ARRAY;
			req_reg   <= '0;
			left_reg  <= 6'h00;
			idx_reg   <= 5'h00;
		end else begin
			state_reg <= state_next;
			mode_reg  <= mode_next;
			req_reg   <= req_next;
			left_reg  <= left_next;
			idx_reg   <= bufwr_next ? idx_reg + 5'h01 : idx_next;
		end
	end

	// pulses and buffer stream toward the write state machine
	always_ff @(posedge mclk) begin
		if (reset) begin
			wsm_start   <= 1'b0;
			buf_wr      <= 1'b0;
			buf_data    <= 16'h0000;
			buf_index   <= 5'h00;
			wsm_suspend <= 1'b0;
			wsm_resume  <= 1'b0;
		end else begin
			wsm_start   <= start_next;
			buf_wr      <= bufwr_next;
			buf_data    <= bufwr_next ? data_s2 : buf_data;
			buf_index   <= bufwr_next ? idx_reg : buf_index;
			wsm_suspend <= susp_next;
			wsm_resume  <= resume_next;
		end
	end

	// ==========================================================
	// status register: engine may only set error bits
	// set wins over clear so an error in the clearing cycle is kept
	wire [7:0] err_set = (wsm_err_set | (seq_err ? `FCD_SR_SEQ_ERR : 8'h00)) & `FCD_SR_ERR_MASK;
	assign err_next = (clear_err ? 8'h00 : err_reg) | err_set;

	always_ff @(posedge mclk) begin
		if (reset) begin
			err_reg <= 8'h00;
		end else begin
			err_reg <= err_next;
		end
	end

	// ready follows the engine; suspend bit shows with ready
	wire [7:0] status_live = err_reg |
	                         ({7'h00, ~wsm_busy | wsm_suspended} << `FCD_SR_READY) |
	                         ({7'h00, wsm_suspended} << `FCD_SR_PROG_SUSP);

	always_ff @(posedge mclk) begin
		if (reset) begin
			status <= `FCD_SR_RESET;
		end else begin
			status <= status_live;
		end
	end

	// ==========================================================
	// read path: status is frozen for the length of one read
	logic [7:0] status_snap;
	// the first beat of a read already shows the value being frozen, never the stale one
	wire  [7:0]  status_view = rd_start ? status : status_snap;
	wire  [15:0] rd_mux = (mode_reg == fcd_pkg::FCD_RD_ARRAY)  ? array_data :
	                      (mode_reg == fcd_pkg::FCD_RD_STATUS) ? {8'h00, status_view} :
	                      (mode_reg == fcd_pkg::FCD_RD_IDENT)  ? ident_data :
	                      {8'h00, query_data};

	always_ff @(posedge mclk) begin
		if (reset) begin
			status_snap <= `FCD_SR_RESET;
			dq_out      <= 16'h0000;
			dq_oe_n     <= 1'b1;
			read_addr   <= '0;
		end else begin
			status_snap <= rd_start ? status : status_snap;
			dq_out      <= rd_mux;
			dq_oe_n     <= ~(rd_sync[1] & ~wr_sync[1]);
			read_addr   <= addr_s2;
		end
	end

	assign read_mode = mode_reg;
	assign wsm_req   = req_reg;
endmodule : fcd_decoder

//--- fcd_decoder_sva.sv
// checker on the ports of the flash command decoder
`timescale 1ns/1ns
module fcd_decoder_sva (
	input wire logic                       mclk,
	input wire logic                       reset,
	input wire logic                       write_en_n,
	input wire logic [15:0]                array_data,
	input wire logic [15:0]                dq_out,
	input wire logic                       dq_oe_n,
	input wire fcd_pkg::fcd_read_mode_type read_mode,
	input wire fcd_pkg::fcd_wsm_req_type   wsm_req,
	input wire logic                       wsm_start,
	input wire logic                       wsm_suspend,
	input wire logic                       wsm_busy,
	input wire logic                       wsm_suspended,
	input wire logic [7:0]                 wsm_err_set,
	input wire logic [7:0]                 status
);
	// ==========
	// cycles since the last write strobe; an error bit may only drop shortly after a write
	logic [3:0] since_wr_reg;
	always_ff @(posedge mclk) begin
		if (reset || !write_en_n) since_wr_reg <= 4'h0;
		else if (since_wr_reg != 4'hF) since_wr_reg <= since_wr_reg + 4'h1;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// ==========
	// assertions
	a_reset_state: assert property ($fell(reset) |-> status == 8'h80 && read_mode == fcd_pkg::FCD_RD_ARRAY)
		else $error("state after reset wrong");
	a_array_full: assert property (read_mode == fcd_pkg::FCD_RD_ARRAY && !dq_oe_n |-> dq_out == array_data)
		else $error("array read not full width");
	a_status_pad: assert property (read_mode == fcd_pkg::FCD_RD_STATUS && !dq_oe_n |-> dq_out[15:8] == 8'h00)
		else $error("status read upper byte not zero");
	a_query_pad: assert property (read_mode == fcd_pkg::FCD_RD_QUERY && !dq_oe_n |-> dq_out[15:8] == 8'h00)
		else $error("query read upper byte not zero");
	a_start_status: assert property (wsm_start |-> read_mode == fcd_pkg::FCD_RD_STATUS ##1 !wsm_start)
		else $error("start without status mode");
	a_word_count: assert property (wsm_start && wsm_req.op == fcd_pkg::FCD_OP_WORD |-> wsm_req.count == 6'h01)
		else $error("word program count wrong");
	a_buf_count: assert property (wsm_start && wsm_req.op == fcd_pkg::FCD_OP_BUFFER |-> wsm_req.count inside {[1:32]})
		else $error("buffer count out of range");
	a_busy_no_start: assert property (wsm_busy |-> !wsm_start)
		else $error("start while engine busy");
	a_susp_busy: assert property (wsm_suspend |-> wsm_busy && !wsm_suspended)
		else $error("suspend outside operation");
	a_susp_status: assert property (wsm_suspended && wsm_busy |=> status[2] && status[7])
		else $error("suspend not shown in status");
	a_err_set: assert property (wsm_err_set[4] |-> ##2 status[4])
		else $error("error bit not set");
	a_err_hold: assert property ($fell(|(status & 8'h3A)) |-> since_wr_reg < 4'hC)
		else $error("error bit cleared without command");
endmodule : fcd_decoder_sva

//--- fcd_wsm_model.sv
// engine model answering the decoder's start, suspend and resume pulses
`timescale 1ns/1ns
module fcd_wsm_model (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       wsm_start,
	input  wire logic       wsm_suspend,
	input  wire logic       wsm_resume,
	input  wire logic [9:0] op_len,
	input  wire logic       op_fail,
	output logic            wsm_busy,
	output logic            wsm_suspended,
	output logic [7:0]      wsm_err_set
);
	logic [9:0] left_reg;
	// ==========
	// busy the cycle after start; count frozen while suspended; errors only ever set
	always_ff @(posedge mclk) begin
		wsm_err_set <= 8'h00;
		if (reset) begin
			wsm_busy <= 1'b0;
			wsm_suspended <= 1'b0;
			left_reg <= 10'h000;
		end else if (wsm_start) begin
			wsm_busy <= 1'b1;
			left_reg <= op_len;
		end else if (wsm_suspend) wsm_suspended <= 1'b1;
		else if (wsm_resume) wsm_suspended <= 1'b0;
		else if (wsm_busy && !wsm_suspended) begin
			if (left_reg == 10'h000) begin
				wsm_busy <= 1'b0;
				wsm_err_set <= op_fail ? 8'h10 : 8'h00;
			end else left_reg <= left_reg - 10'h001;
		end
	end
endmodule : fcd_wsm_model

//--- fcd_decoder_tb.sv
// self-checking bench for the flash command decoder
`timescale 1ns/1ns
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin n_errors++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module fcd_decoder_tb;
	logic                       mclk = 1'b0, reset = 1'b1, op_fail = 1'b0;
	logic                       chip_sel_n = 1'b1, write_en_n = 1'b1, out_en_n = 1'b1, address_valid_n = 1'b1;
	logic [23:0]                addr = 24'h000000;
	logic [23:0]                read_addr;
	logic [15:0]                dq_in = 16'h0000, dq_out, buf_data, last_data;
	logic [9:0]                 op_len = 10'h00A;
	logic                       dq_oe_n, wsm_start, buf_wr, wsm_suspend, wsm_resume, wsm_busy, wsm_suspended;
	logic [4:0]                 buf_index, last_idx;
	logic [7:0]                 wsm_err_set, status;
	fcd_pkg::fcd_read_mode_type read_mode;
	fcd_pkg::fcd_wsm_req_type   wsm_req, req_seen;
	int                         n_errors = 0, total_checks = 0, n_buf = 0, n0;
	always #50 mclk = ~mclk;
	fcd_decoder fcd_decoder_inst (.mclk(mclk), .reset(reset), .chip_sel_n(chip_sel_n), .write_en_n(write_en_n),
		.out_en_n(out_en_n), .address_valid_n(address_valid_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe_n(dq_oe_n), .read_addr(read_addr), .array_data(16'hA5C3), .ident_data(16'h5AE1), .query_data(8'h3C),
		.read_mode(read_mode), .wsm_req(wsm_req), .wsm_start(wsm_start), .buf_wr(buf_wr), .buf_data(buf_data),
		.buf_index(buf_index), .wsm_suspend(wsm_suspend), .wsm_resume(wsm_resume), .wsm_busy(wsm_busy),
		.wsm_suspended(wsm_suspended), .wsm_err_set(wsm_err_set), .status(status));
	fcd_wsm_model fcd_wsm_model_inst (.mclk(mclk), .reset(reset), .wsm_start(wsm_start), .wsm_suspend(wsm_suspend),
		.wsm_resume(wsm_resume), .op_len(op_len), .op_fail(op_fail), .wsm_busy(wsm_busy),
		.wsm_suspended(wsm_suspended), .wsm_err_set(wsm_err_set));
	// ==========
	// record requests and buffer loads as they pass
	always @(posedge mclk) begin
		if (wsm_start) req_seen <= wsm_req;
		if (buf_wr) begin
			n_buf <= n_buf + 1;
			last_idx <= buf_index;
			last_data <= buf_data;
		end
	end
	// ==========
	// bus tasks: write strobes held three cycles, read strobes six, so the two-flop synchronisers see them
	task automatic wr(input logic [23:0] a, input logic [15:0] d);
		@(posedge mclk);
		{chip_sel_n, write_en_n, addr, dq_in} <= {2'b00, a, d};
		repeat (3) @(posedge mclk);
		{chip_sel_n, write_en_n} <= 2'b11;
		repeat (8) @(posedge mclk);
	endtask : wr
	// select toggled for every read so status is refreshed
	task automatic rd(input string n, input logic [15:0] e);
		@(posedge mclk);
		{chip_sel_n, out_en_n} <= 2'b00;
		repeat (6) @(posedge mclk);
		`CHK(n, e, dq_out)
		`CHK({n, " drive"}, 1'b0, dq_oe_n)
		{chip_sel_n, out_en_n} <= 2'b11;
		repeat (4) @(posedge mclk);
	endtask : rd
	task automatic wait_idle();
		for (int i = 0; i < 600 && wsm_busy !== 1'b0; i++) @(posedge mclk);
		`CHK("engine idle", 1'b0, wsm_busy)
		repeat (6) @(posedge mclk);
	endtask : wait_idle
	task automatic summarize();
		if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	// watchdog: whole sequence needs well under this many cycles
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		summarize();
	end
	// ==========
	// test sequence
	initial begin
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		repeat (4) @(posedge mclk);
		rd("array", 16'hA5C3);
		wr(24'h0, 16'h0070);
		rd("status", 16'h0080);
		wr(24'h0, 16'h0090);
		rd("ident", 16'h5AE1);
		wr(24'h0, 16'h0098);
		rd("query", 16'h003C);
		wr(24'h0, 16'h00FF);
		rd("array", 16'hA5C3);
		op_len <= 10'h050;
		for (int k = 0; k < 2; k++) begin
			wr(24'h0, k ? 16'h0010 : 16'h0040);
			wr(24'(24'hABC + k), 16'(16'h1234 + k));
			`CHK("word req", {fcd_pkg::FCD_OP_WORD, 6'h01, 32'(24'hABC + k), 16'(16'h1234 + k)}, req_seen)
			wr(24'h0, 16'h0090);
			`CHK("busy mode", fcd_pkg::FCD_RD_STATUS, read_mode)
			rd("busy status", 16'h0000);
			wait_idle();
			rd("done status", 16'h0080);
			wr(24'h0, 16'h00FF);
			rd("array again", 16'hA5C3);
		end
		// failing program: error stays through other commands, only clear removes it
		{op_len, op_fail} <= {10'h00A, 1'b1};
		wr(24'h0, 16'h0040);
		wr(24'h10, 16'h0001);
		wait_idle();
		op_fail <= 1'b0;
		rd("err set", 16'h0090);
		wr(24'h0, 16'h0070);
		rd("err kept", 16'h0090);
		wr(24'h0, 16'h0050);
		rd("err clear", 16'h0080);
		// suspend and resume of a long program
		op_len <= 10'h0C8;
		wr(24'h0, 16'h0040);
		wr(24'h20, 16'h0002);
		wr(24'h0, 16'h00B0);
		rd("suspended", 16'h0084);
		wr(24'h0, 16'h00D0);
		wait_idle();
		rd("resumed", 16'h0080);
		// read held open: status stays frozen until address valid pulses
		wr(24'h0, 16'h0040);
		wr(24'h30, 16'h0003);
		{chip_sel_n, out_en_n} <= 2'b00;
		wait_idle();
		`CHK("held status", 16'h0000, dq_out)
		`CHK("read addr", 24'h000030, read_addr)
		address_valid_n <= 1'b0;
		repeat (3) @(posedge mclk);
		address_valid_n <= 1'b1;
		repeat (4) @(posedge mclk);
		`CHK("refreshed", 16'h0080, dq_out)
		{chip_sel_n, out_en_n} <= 2'b11;
		repeat (4) @(posedge mclk);
		// full buffer of 32 words
		op_len <= 10'h00A;
		wr(24'h0, 16'h00E8);
		wr(24'h0, 16'h001F);
		n0 = n_buf;
		for (int i = 0; i < 32; i++) wr(24'(i), 16'(i));
		wr(24'h0, 16'h00D0);
		`CHK("buf words", 32, n_buf - n0)
		`CHK("buf index", 5'h1F, last_idx)
		`CHK("buf data", 16'h001F, last_data)
		`CHK("buf req", {fcd_pkg::FCD_OP_BUFFER, 6'h20}, {req_seen.op, req_seen.count})
		wait_idle();
		// buffer sequence without confirm gives a sequence error
		wr(24'h0, 16'h00E8);
		wr(24'h0, 16'h0000);
		wr(24'h0, 16'h0055);
		wr(24'h0, 16'h0070);
		rd("seq err", 16'h00B0);
		wr(24'h0, 16'h0050);
		// factory mode: confirm latches address and data, then codes are ignored
		op_len <= 10'h064;
		wr(24'h0, 16'h0080);
		wr(24'h000F0F, 16'h00D0);
		`CHK("fact req", {fcd_pkg::FCD_OP_FACTORY, 32'h00000F0F, 16'h00D0}, {req_seen.op, req_seen.addr, req_seen.data})
		n0 = n_buf;
		wr(24'h0, 16'h00FF);
		`CHK("fact mode", fcd_pkg::FCD_RD_STATUS, read_mode)
		`CHK("fact load", 1, n_buf - n0)
		`CHK("fact data", 16'h00FF, last_data)
		wait_idle();
		wr(24'h0, 16'h00FF);
		rd("array end", 16'hA5C3);
		summarize();
	end
endmodule : fcd_decoder_tb
bind fcd_decoder fcd_decoder_sva fcd_decoder_sva_inst (.mclk(mclk), .reset(reset), .write_en_n(write_en_n),
	.array_data(array_data), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .read_mode(read_mode), .wsm_req(wsm_req),
	.wsm_start(wsm_start), .wsm_suspend(wsm_suspend), .wsm_busy(wsm_busy), .wsm_suspended(wsm_suspended),
	.wsm_err_set(wsm_err_set), .status(status));
